// ### bit_collector.sv
// Serial field collector, least significant bit first.
`timescale 1ns/10ps
module bit_collector (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clr,
	input wire logic stb,
	input wire logic bit_in,
	input wire logic [6:0] len,
	output logic last,
	output logic [63:0] word
);
	logic [63:0] sh;
	logic [6:0] cnt;
	logic [63:0] merged;

	// The last bit is merged combinationally so the next field can
	// start on the very next cycle without a gap.
	assign merged = {bit_in, sh[63:1]};
	assign last = stb && (cnt == len - 7'h01);
	assign word = merged >> (7'h40 - len);

	// Shift and count; a link reset drops any partial field.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sh <= 64'h0000000000000000;
			cnt <= 7'h00;
		end else if (clr) begin
			cnt <= 7'h00;
		end else if (stb) begin
			sh <= merged;
			cnt <= last ? 7'h00 : cnt + 7'h01;
		end
	end
endmodule : bit_collector

// ### guard_device.sv
// Device end: password guarded commands, variant code and samples counter.
//
// Our own choice: the guard_link_if serial link port.
`timescale 1ns/10ps
module guard_device
	import guard_pkg::*;
#(
	parameter logic [7:0] VARIANT = VARIANT_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic nrst,
	guard_link_if.dev link,
	input wire logic sample_tick,
	input wire logic alarm_test_tick,
	input wire logic start_on_alarm_select,
	output logic mission_active_flag,
	output logic [23:0] samples_count,
	output logic mem_clear_pulse,
	output logic cmd_reject
);
	typedef enum logic [2:0] {
		ST_CMD = 3'h0,
		ST_ADDR = 3'h1,
		ST_PWD = 3'h3,
		ST_XFER = 3'h2,
		ST_HALT = 3'h6
	} dev_state_e;

	dev_state_e state;
	logic [7:0] cmd, pwen, cmd_now;
	logic [15:0] ta, ptr;
	logic [4:0] ofs, end_ofs;
	logic [7:0] sp [32];
	logic [63:0] read_secret, full_secret, word;
	logic [6:0] len;
	logic sp_full, last, rx_stb, checking, full_ok, pwd_ok, pwd_done;
	logic go_copy, go_clear, go_start, go_stop, go_force;

	// Field length follows the phase the command is in.
	always_comb begin
		unique case (state)
			ST_CMD: len = LEN_CMD;
			ST_ADDR: len = LEN_ADDR;
			ST_PWD: len = LEN_PWD;
			default: len = LEN_BYTE;
		endcase
	end

	// A halted device ignores all link bits.
	assign rx_stb = link.bit_stb && (state != ST_HALT);

	bit_collector u_rx (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clr(link.link_rst),
		.stb(rx_stb),
		.bit_in(link.bit_val),
		.len(len),
		.last(last),
		.word(word)
	);

	// Password decision, made only once all 64 bits have arrived.
	assign cmd_now = word[7:0];
	assign checking = (pwen == PWEN_PATTERN);
	assign full_ok = !checking || (word == full_secret);
	assign pwd_ok = full_ok
		|| (cmd == CMD_READ_MEM && word == read_secret);
	assign pwd_done = last && (state == ST_PWD);
	assign go_copy = pwd_done && pwd_ok && (cmd == CMD_COPY_SP);
	assign go_clear = pwd_done && pwd_ok && (cmd == CMD_CLEAR_MEM);
	assign go_start = pwd_done && pwd_ok && (cmd == CMD_START);
	assign go_stop = pwd_done && pwd_ok && (cmd == CMD_STOP);
	// Forced conversion runs straight from the command code.
	assign go_force = last && (state == ST_CMD)
		&& (cmd_now == CMD_FORCE_CONV);

	// Command sequencing.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_HALT;
			cmd <= 8'h00;
		end else if (link.link_rst) begin
			state <= ST_CMD;
		end else if (last) begin
			unique case (state)
				ST_CMD: begin
					cmd <= cmd_now;
					if (cmd_now == CMD_WRITE_SP
						|| cmd_now == CMD_READ_MEM) begin
						state <= ST_ADDR;
					end else if (cmd_now == CMD_READ_SP) begin
						state <= ST_XFER;
					end else if (cmd_now == CMD_COPY_SP
						|| cmd_now == CMD_CLEAR_MEM
						|| cmd_now == CMD_START
						|| cmd_now == CMD_STOP) begin
						state <= ST_PWD;
					end else begin
						state <= ST_HALT;
					end
				end
				ST_ADDR: begin
					state <= (cmd == CMD_READ_MEM) ? ST_PWD : ST_XFER;
				end
				ST_PWD: begin
					// Only a granted read keeps the link open.
					state <= (pwd_ok && cmd == CMD_READ_MEM)
						? ST_XFER : ST_HALT;
				end
				ST_XFER: state <= ST_XFER;
				ST_HALT: state <= ST_HALT;
			endcase
		end
	end

	// Target address, read pointer and scratchpad fill.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ta <= 16'h0000;
			ptr <= 16'h0000;
			ofs <= 5'h00;
			end_ofs <= 5'h00;
			sp_full <= 1'b0;
		end else if (last && state == ST_CMD && cmd_now == CMD_READ_SP) begin
			ofs <= ta[4:0];
		end else if (last && state == ST_ADDR) begin
			ta <= word[15:0];
			ptr <= word[15:0];
			ofs <= word[4:0];
			if (cmd == CMD_WRITE_SP) begin
				sp_full <= 1'b0;
				end_ofs <= word[4:0];
			end
		end else if (state == ST_XFER && cmd == CMD_WRITE_SP) begin
			// Bytes past the page end are dropped, not wrapped.
			if (last && !sp_full) begin
				end_ofs <= ofs;
				ofs <= ofs + 5'h01;
				sp_full <= (ofs == SP_LAST);
			end
		end else if (state == ST_XFER && link.byte_req) begin
			ofs <= ofs + 5'h01;
			ptr <= ptr + 16'h0001;
		end
	end

	// Scratchpad storage.
	always_ff @(posedge sys_clk) begin
		if (state == ST_XFER && cmd == CMD_WRITE_SP && last && !sp_full) begin
			sp[ofs] <= cmd_now;
		end
	end

	// Copy into the enable byte and both secrets, one cycle for the page.
	always_ff @(posedge sys_clk or negedge nrst) begin
		logic [15:0] a;
		int k;
		if (!nrst) begin
			pwen <= PWEN_RESET;
			read_secret <= SECRET_RESET;
			full_secret <= SECRET_RESET;
		end else if (go_copy && end_ofs == SP_LAST) begin
			for (int i = 0; i < 32; i++) begin
				a = {ta[15:5], 5'(i)};
				k = int'(a[2:0]);
				if (5'(i) >= ta[4:0] && !mission_active_flag) begin
					if (a == ADDR_PWEN) begin
						pwen <= sp[i];
					end
					if (a[15:3] == ADDR_READ_PW[15:3]) begin
						read_secret[k*8 +: 8] <= sp[i];
					end
					if (a[15:3] == ADDR_FULL_PW[15:3]) begin
						full_secret[k*8 +: 8] <= sp[i];
					end
				end
			end
		end
	end

	// Command outcomes: mission flag, clear strobe, mismatch report.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mission_active_flag <= 1'b0;
			mem_clear_pulse <= 1'b0;
			cmd_reject <= 1'b0;
		end else begin
			mem_clear_pulse <= go_clear;
			cmd_reject <= pwd_done && !pwd_ok;
			if (go_start) begin
				mission_active_flag <= 1'b1;
			end else if (go_stop) begin
				mission_active_flag <= 1'b0;
			end
		end
	end

	// Lifetime counter. It saturates rather than wrapping so an old
	// part never looks fresh; two wake-ups in one cycle add only one.
	always_ff @(posedge sys_clk or negedge nrst) begin
		logic [1:0] inc;
		logic [24:0] sum;
		if (!nrst) begin
			samples_count <= COUNT_RESET;
		end else begin
			inc = 2'h0;
			if (mission_active_flag && (sample_tick
				|| (alarm_test_tick && start_on_alarm_select))) begin
				inc = inc + 2'h1;
			end
			if (go_force && !mission_active_flag) begin
				inc = inc + 2'h1;
			end
			sum = {1'b0, samples_count} + {23'h000000, inc};
			samples_count <= sum[24] ? COUNT_MAX : sum[23:0];
		end
	end

	// Memory byte as seen by a read; secrets always read as zero.
	function automatic logic [7:0] mem_byte(input logic [15:0] a);
		unique case (a)
			ADDR_COUNT_LO: mem_byte = samples_count[7:0];
			ADDR_COUNT_MID: mem_byte = samples_count[15:8];
			ADDR_COUNT_HI: mem_byte = samples_count[23:16];
			ADDR_VARIANT: mem_byte = VARIANT;
			ADDR_PWEN: mem_byte = pwen;
			default: mem_byte = 8'h00;
		endcase
	endfunction : mem_byte

	// Byte answers: one cycle after each request, idle byte when no
	// read is open so the master never waits forever.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			link.byte_stb <= 1'b0;
			link.byte_val <= IDLE_BYTE;
		end else begin
			link.byte_stb <= link.byte_req;
			if (link.byte_req) begin
				if (state == ST_XFER && cmd == CMD_READ_MEM) begin
					link.byte_val <= mem_byte(ptr);
				end else if (state == ST_XFER && cmd == CMD_READ_SP) begin
					link.byte_val <= sp[ofs];
				end else begin
					link.byte_val <= IDLE_BYTE;
				end
			end
		end
	end
endmodule : guard_device

// ### guard_host.sv
// Link master end, driven by software through Avalon-MM registers.
`timescale 1ns/10ps
module guard_host
	import guard_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	guard_link_if.host link,
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_SEND = 2'h1,
		HS_READ = 2'h3
	} host_state_e;

	host_state_e state;
	logic [31:0] data;
	logic [31:0] sh;
	logic [4:0] left;
	logic [7:0] rx_byte;
	logic busy;
	logic ctrl_wr;

	// Writes stall while a link operation runs; reads never stall.
	assign busy = (state != HS_IDLE) || link.link_rst;
	assign avs_waitrequest = avs_write && busy;
	assign ctrl_wr = avs_write && !busy && (avs_address == HOST_CTRL);

	// Register reads; zero outside a read so nothing stale sits on the bus.
	always_comb begin
		unique case (avs_read ? avs_address : HOST_CTRL)
			HOST_DATA: avs_readdata = data;
			HOST_STAT: avs_readdata = {16'h0000, rx_byte, 7'h00, busy};
			default: avs_readdata = 32'h00000000;
		endcase
	end

	// Data word for the next send.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			data <= 32'h00000000;
		end else if (avs_write && !busy && avs_address == HOST_DATA) begin
			data <= avs_writedata;
		end
	end

	// Link sequencing. Bits go out one per cycle, bit 0 first, with no
	// idle cycle inside an operation; bit_stb drops for at least one cycle
	// between successive operations, so a command code and its 64-bit password never go back to back.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= HS_IDLE;
			sh <= 32'h00000000;
			left <= 5'h00;
			rx_byte <= 8'h00;
			link.link_rst <= 1'b0;
			link.bit_stb <= 1'b0;
			link.bit_val <= 1'b0;
			link.byte_req <= 1'b0;
		end else begin
			link.link_rst <= 1'b0;
			link.byte_req <= 1'b0;
			unique case (state)
				HS_IDLE: begin
					link.bit_stb <= 1'b0;
					if (ctrl_wr) begin
						unique case (avs_writedata[CTRL_OP_LSB +: 2])
							OP_SEND_BITS: begin
								link.bit_stb <= 1'b1;
								link.bit_val <= data[0];
								sh <= {1'b0, data[31:1]};
								left <= avs_writedata[CTRL_NB_LSB +: 5];
								state <= HS_SEND;
							end
							OP_READ_BYTE: begin
								link.byte_req <= 1'b1;
								state <= HS_READ;
							end
							default: link.link_rst <= 1'b1;
						endcase
					end
				end
				HS_SEND: begin
					// Full 64-bit passwords are two 32-bit sends.
					if (left == 5'h00) begin
						link.bit_stb <= 1'b0;
						state <= HS_IDLE;
					end else begin
						link.bit_val <= sh[0];
						sh <= {1'b0, sh[31:1]};
						left <= left - 5'h01;
					end
				end
				HS_READ: begin
					if (link.byte_stb) begin
						rx_byte <= link.byte_val;
						state <= HS_IDLE;
					end
				end
				default: state <= HS_IDLE;
			endcase
		end
	end
endmodule : guard_host

// ### guard_link_if.sv
// Link between the link master and the guarded device.
`timescale 1ns/10ps
interface guard_link_if;
	logic link_rst;
	logic bit_stb;
	logic bit_val;
	logic byte_req;
	logic byte_stb;
	logic [7:0] byte_val;

	modport dev (
		input link_rst,
		input bit_stb,
		input bit_val,
		input byte_req,
		output byte_stb,
		output byte_val
	);

	modport host (
		output link_rst,
		output bit_stb,
		output bit_val,
		output byte_req,
		input byte_stb,
		input byte_val
	);
endinterface : guard_link_if

// ### guard_link_sva.sv
// Checker for the link between the link master and the guarded device.
`timescale 1ns/10ps
module guard_link_sva
	import guard_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic bit_stb,
	input wire logic byte_req,
	input wire logic byte_stb,
	input wire logic [7:0] byte_val,
	input wire logic sample_tick,
	input wire logic alarm_test_tick,
	input wire logic start_on_alarm_select,
	input wire logic mission_active_flag,
	input wire logic [23:0] samples_count,
	input wire logic mem_clear_pulse,
	input wire logic cmd_reject
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// A command result may land one cycle after the last bit, so both count.
	sequence recent_bit;
		$past(bit_stb) || $past(bit_stb, 2);
	endsequence
	sequence answer_next;
		##1 byte_stb;
	endsequence

	// A wake-up during a mission moves the counter at the very next edge.
	property bumps(ev);
		ev && samples_count != COUNT_MAX |=> $changed(samples_count);
	endproperty

	byte_answer_a: assert property (byte_req |-> answer_next)
		else $error("Byte request not answered in the next cycle.");
	byte_cause_a: assert property (byte_stb |-> $past(byte_req))
		else $error("Byte strobe without a request.");
	byte_hold_a: assert property (!byte_stb |-> $stable(byte_val))
		else $error("Answer byte changed without a strobe.");
	reject_once_a: assert property (cmd_reject |=> !cmd_reject)
		else $error("Reject pulse longer than one cycle.");
	reject_quiet_a: assert property (cmd_reject |->
		$stable(mission_active_flag) && !mem_clear_pulse)
		else $error("Rejected command had a side effect.");
	reject_cause_a: assert property (cmd_reject |-> recent_bit)
		else $error("Reject without a received bit.");
	count_step_a: assert property ($changed(samples_count) |->
		(samples_count - $past(samples_count)) inside {24'h1, 24'h2})
		else $error("Samples counter moved by a wrong step.");
	tick_count_a: assert property (
		bumps(mission_active_flag && sample_tick))
		else $error("Mission wake-up did not count.");
	alarm_count_a: assert property (bumps(mission_active_flag &&
		start_on_alarm_select && alarm_test_tick))
		else $error("Alarm test wake-up did not count.");
	idle_count_a: assert property (!mission_active_flag &&
		!$past(mission_active_flag) && !bit_stb && !$past(bit_stb)
		|=> $stable(samples_count))
		else $error("Counter moved outside a mission without a command.");
	flag_rise_a: assert property ($rose(mission_active_flag)
		|-> recent_bit)
		else $error("Mission flag rose without a command.");
	flag_fall_a: assert property ($fell(mission_active_flag)
		|-> recent_bit)
		else $error("Mission flag fell without a command.");
	clear_cause_a: assert property (mem_clear_pulse |-> recent_bit)
		else $error("Clear pulse without a command.");
endmodule : guard_link_sva

// ### guard_pkg.sv
// Shared constants for the password access guard and its link master.
package guard_pkg;

	// Link command codes, sent least significant bit first.
	localparam logic [7:0] CMD_WRITE_SP = 8'h0F;
	localparam logic [7:0] CMD_READ_SP = 8'hAA;
	localparam logic [7:0] CMD_COPY_SP = 8'h99;
	localparam logic [7:0] CMD_READ_MEM = 8'h69;
	localparam logic [7:0] CMD_CLEAR_MEM = 8'h96;
	localparam logic [7:0] CMD_START = 8'hCC;
	localparam logic [7:0] CMD_STOP = 8'h33;
	localparam logic [7:0] CMD_FORCE_CONV = 8'h55;

	// Field lengths on the link, in bits.
	localparam logic [6:0] LEN_CMD = 7'h08;
	localparam logic [6:0] LEN_ADDR = 7'h10;
	localparam logic [6:0] LEN_PWD = 7'h40;
	localparam logic [6:0] LEN_BYTE = 7'h08;

	// Device memory map.
	localparam logic [15:0] ADDR_COUNT_LO = 16'h0223;
	localparam logic [15:0] ADDR_COUNT_MID = 16'h0224;
	localparam logic [15:0] ADDR_COUNT_HI = 16'h0225;
	localparam logic [15:0] ADDR_VARIANT = 16'h0226;
	localparam logic [15:0] ADDR_PWEN = 16'h0227;
	localparam logic [15:0] ADDR_READ_PW = 16'h0228;
	localparam logic [15:0] ADDR_FULL_PW = 16'h0230;

	// Checking pattern, reset values and scratchpad limits.
	localparam logic [7:0] PWEN_PATTERN = 8'hAA;
	localparam logic [7:0] PWEN_RESET = 8'h00;
	localparam logic [63:0] SECRET_RESET = 64'h0000000000000000;
	localparam logic [23:0] COUNT_RESET = 24'h000000;
	localparam logic [23:0] COUNT_MAX = 24'hFFFFFF;
	localparam logic [4:0] SP_LAST = 5'h1F;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	// Arbitrary neutral value, not tied to any real part.
	localparam logic [7:0] VARIANT_DEFAULT = 8'h5A;

	// Link master register offsets (Avalon word addresses).
	localparam logic [1:0] HOST_CTRL = 2'h0;
	localparam logic [1:0] HOST_DATA = 2'h1;
	localparam logic [1:0] HOST_STAT = 2'h2;
	// Control word fields.
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_NB_LSB = 8;
	localparam logic [1:0] OP_LINK_RESET = 2'h0;
	localparam logic [1:0] OP_SEND_BITS = 2'h1;
	localparam logic [1:0] OP_READ_BYTE = 2'h2;

endpackage : guard_pkg

// ### testbench.sv
// Self-checking bench for the link master and guarded device pair.
`timescale 1ns/10ps
module testbench
	import guard_pkg::*;
;
	logic sys_clk, nrst, avs_read, avs_write, avs_waitrequest;
	logic [1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic sample_tick, alarm_test_tick, start_on_alarm_select;
	logic mission_active_flag, mem_clear_pulse, cmd_reject;
	logic [23:0] samples_count, cnt;
	logic [7:0] pwen;
	logic [7:0] sp [32];
	int fail_count, cmp_count, rej_n, clr_n;
	localparam logic [63:0] RPW = 64'h1122334455667788;
	localparam logic [63:0] FPW = 64'h99AABBCCDDEEFF01;
	localparam logic [63:0] BAD = 64'h0BAD0BAD0BAD0BAD;

	guard_link_if link ();
	guard_host i_guard_host (.sys_clk(sys_clk), .nrst(nrst), .link(link),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	guard_device i_guard_device (.sys_clk(sys_clk), .nrst(nrst),
		.link(link), .sample_tick(sample_tick),
		.alarm_test_tick(alarm_test_tick),
		.start_on_alarm_select(start_on_alarm_select),
		.mission_active_flag(mission_active_flag),
		.samples_count(samples_count), .mem_clear_pulse(mem_clear_pulse),
		.cmd_reject(cmd_reject));
	guard_link_sva i_guard_link_sva (.sys_clk(sys_clk), .nrst(nrst),
		.bit_stb(link.bit_stb), .byte_req(link.byte_req),
		.byte_stb(link.byte_stb), .byte_val(link.byte_val),
		.sample_tick(sample_tick), .alarm_test_tick(alarm_test_tick),
		.start_on_alarm_select(start_on_alarm_select),
		.mission_active_flag(mission_active_flag),
		.samples_count(samples_count), .mem_clear_pulse(mem_clear_pulse),
		.cmd_reject(cmd_reject));

	// Free-running system clock.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// One-cycle pulses are easy to miss by polling, so they are counted here.
	always @(posedge sys_clk) begin
		if (cmd_reject === 1'b1) rej_n++;
		if (mem_clear_pulse === 1'b1) clr_n++;
	end

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d.", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tmo();
		fail_count++;
		test_done();
	endtask : tmo

	// One Avalon access; waitrequest and readdata are settled at the negedge.
	task automatic av(input logic wr, input logic [1:0] a,
		input logic [31:0] d, output logic [31:0] q);
		logic w;
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(negedge sys_clk);
			w = avs_waitrequest;
			q = avs_readdata;
			@(posedge sys_clk);
			n++;
		end while (w !== 1'b0 && n < 500);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (w !== 1'b0) tmo();
		@(posedge sys_clk);
	endtask : av

	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		logic [31:0] q;
		av(1'b1, a, d, q);
	endtask : wr

	task automatic idle();
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			av(1'b0, HOST_STAT, 32'h0, q);
			n++;
		end while (q[0] !== 1'b0 && n < 200);
		if (q[0] !== 1'b0) tmo();
	endtask : idle

	task automatic send(input logic [31:0] d, input int n);
		wr(HOST_DATA, d);
		wr(HOST_CTRL, (32'(n - 1) << CTRL_NB_LSB) | 32'(OP_SEND_BITS));
		idle();
	endtask : send

	task automatic cmd(input logic [7:0] c);
		wr(HOST_CTRL, 32'(OP_LINK_RESET));
		idle();
		send(32'(c), 8);
	endtask : cmd

	task automatic pw(input logic [63:0] p);
		send(p[31:0], 32);
		send(p[63:32], 32);
	endtask : pw

	task automatic rdb(output logic [7:0] b);
		logic [31:0] q;
		wr(HOST_CTRL, 32'(OP_READ_BYTE));
		idle();
		av(1'b0, HOST_STAT, 32'h0, q);
		b = q[15:8];
	endtask : rdb

	function automatic logic [7:0] mem_exp(input logic [15:0] a);
		case (a)
			ADDR_COUNT_LO: return cnt[7:0];
			ADDR_COUNT_MID: return cnt[15:8];
			ADDR_COUNT_HI: return cnt[23:16];
			ADDR_VARIANT: return VARIANT_DEFAULT;
			ADDR_PWEN: return pwen;
			default: return 8'h00;
		endcase
	endfunction : mem_exp

	// Reads eight bytes from the counter up into the read secret.
	task automatic rdm(input logic [63:0] p, input logic ok);
		logic [7:0] b;
		logic [7:0] e;
		cmd(CMD_READ_MEM);
		send(32'(ADDR_COUNT_LO), 16);
		pw(p);
		for (int i = 0; i < 8; i++) begin
			rdb(b);
			e = ok ? mem_exp(ADDR_COUNT_LO + 16'(i)) : IDLE_BYTE;
			chk("mem byte", b, e);
		end
	endtask : rdm

	task automatic wsp(input logic [15:0] a, input int n);
		cmd(CMD_WRITE_SP);
		send(32'(a), 16);
		for (int i = 0; i < n; i++) send(32'(sp[5'(a[4:0] + i)]), 8);
	endtask : wsp

	task automatic copy(input logic [63:0] p);
		cmd(CMD_COPY_SP);
		pw(p);
	endtask : copy

	task automatic tick(input logic alarm);
		if (alarm) alarm_test_tick <= 1'b1;
		else sample_tick <= 1'b1;
		@(posedge sys_clk);
		alarm_test_tick <= 1'b0;
		sample_tick <= 1'b0;
		repeat (3) @(posedge sys_clk);
		cnt = cnt + 24'h1;
	endtask : tick

	// Main sequence.
	initial begin
		int r;
		logic [7:0] b;
		nrst = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{sample_tick, alarm_test_tick, start_on_alarm_select} = '0;
		{fail_count, cmp_count, rej_n, clr_n} = '0;
		cnt = COUNT_RESET;
		pwen = PWEN_RESET;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		chk("count", samples_count, cnt);
		cmd(CMD_FORCE_CONV);
		cmd(CMD_FORCE_CONV);
		cnt = cnt + 24'h2;
		chk("count", samples_count, cnt);
		rdm(BAD, 1'b1);
		// Enable pattern and both secrets go in one page write.
		for (int i = 0; i < 32; i++) sp[i] = 8'h00;
		sp[7] = PWEN_PATTERN;
		for (int i = 0; i < 8; i++) begin
			sp[8 + i] = RPW[8 * i +: 8];
			sp[16 + i] = FPW[8 * i +: 8];
		end
		wsp(ADDR_PWEN, 25);
		cmd(CMD_READ_SP);
		for (int i = 0; i < 3; i++) begin
			rdb(b);
			chk("scratch", b, sp[7 + i]);
		end
		copy(BAD);
		pwen = PWEN_PATTERN;
		r = rej_n;
		rdm(BAD, 1'b0);
		chk("rejects", rej_n, r + 1);
		rdm(RPW, 1'b1);
		rdm(FPW, 1'b1);
		cmd(CMD_FORCE_CONV);
		cnt = cnt + 24'h1;
		chk("count", samples_count, cnt);
		cmd(CMD_START);
		pw(BAD);
		chk("mission", mission_active_flag, 1'b0);
		cmd(CMD_START);
		pw(FPW);
		chk("mission", mission_active_flag, 1'b1);
		tick(1'b0);
		chk("count", samples_count, cnt);
		start_on_alarm_select <= 1'b1;
		tick(1'b1);
		chk("count", samples_count, cnt);
		// A rewrite from the enable byte to the page end during the mission must change nothing.
		for (int i = 0; i < 32; i++) sp[i] = 8'h00;
		wsp(ADDR_PWEN, 25);
		copy(FPW);
		rdm(RPW, 1'b1);
		cmd(CMD_STOP);
		pw(FPW);
		chk("mission", mission_active_flag, 1'b0);
		r = clr_n;
		cmd(CMD_CLEAR_MEM);
		pw(BAD);
		cmd(CMD_CLEAR_MEM);
		pw(FPW);
		chk("clears", clr_n, r + 1);
		wsp(ADDR_VARIANT, 1);
		copy(FPW);
		rdm(FPW, 1'b1);
		wsp(ADDR_VARIANT, 26);
		copy(BAD);
		rdm(FPW, 1'b1);
		copy(FPW);
		pwen = PWEN_RESET;
		rdm(BAD, 1'b1);
		test_done();
	end
endmodule : testbench
